// *** nvac_ctrl.sv ***
// Indirect access controller for data EEPROM and program flash
`timescale 1ns/10ps
// What this block does
// - Data low is byte data, addr low byte address
// - 256 data bytes, low address only
// - Program word 14 bits, address from pair
// - Program range follows memory size parameter
// - One word or byte per operation
// - Byte write erases then programs automatically
// - Internal timer times each write
// - Protected program regions refuse writes
// - Core keeps access; programmer denied when protected
// - Address covers 256 bytes or 8K words
// - Space select bit 7 routes accesses
// - Trigger bits set-only, hardware clears them
// - Store permit gates writes, cleared at power-up
// - Abort flag marks write cut by warm reset
// - Done flag set on completion, software clears
// - Unlock port reads zero, no storage
// - Data high bits 7:6 read zero
// - Addr high bits 7:5 read zero
// - Control bits 6:4 read zero
// - Write needs 55h, AAh, then store trigger
// - Store trigger needs permit already set
// - Clearing permit never alters running write
// - Read data appears next cycle, held
module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter int PROG_WORDS = 8192,
  parameter int WRITE_CYCLES = NVAC_WRITE_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic por_in,
  input wire logic warm_reset_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [2:0] sfr_sel_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic done_flag_clr_in,
  input wire logic [12:0] protect_limit_in,
  input wire logic code_protect_in,
  input wire logic prog_port_req_in,
  input wire logic [7:0] ee_rdata_in,
  input wire logic [13:0] pf_rdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic [7:0] ee_addr_out,
  output logic [7:0] ee_wdata_out,
  output logic ee_erase_out,
  output logic ee_prog_out,
  output logic [12:0] pf_addr_out,
  output logic prog_port_grant_out,
  output logic store_done_flag_out
);
  localparam int AW = NVAC_PROG_ADDR_BITS;
  localparam logic [AW-1:0] ADDR_MAX = AW'(PROG_WORDS - 1);

  logic [7:0] data_low_q;
  logic [5:0] data_high_q;
  logic [7:0] addr_low_q;
  logic [4:0] addr_high_q;
  logic space_q;
  logic fetch_q;
  logic store_q;
  logic permit_q;
  logic abort_q;
  logic fetch_pend_q;
  logic store_running_q;
  nvac_lock_t lock_q;
  nvac_lock_t lock_d;
  logic [7:0] rd_mux_d;
  logic tmr_busy;
  logic tmr_erase;
  logic tmr_done;

  // Register write decoding
  wire wr_dl = sfr_wr_in && (sfr_sel_in == NVAC_SEL_DATA_LOW);
  wire wr_al = sfr_wr_in && (sfr_sel_in == NVAC_SEL_ADDR_LOW);
  wire wr_dh = sfr_wr_in && (sfr_sel_in == NVAC_SEL_DATA_HIGH);
  wire wr_ah = sfr_wr_in && (sfr_sel_in == NVAC_SEL_ADDR_HIGH);
  wire wr_ct = sfr_wr_in && (sfr_sel_in == NVAC_SEL_CONTROL);
  wire wr_ul = sfr_wr_in && (sfr_sel_in == NVAC_SEL_UNLOCK);

  // Program address: high bits above the low byte, range-checked against memory size
  wire [AW-1:0] prog_addr = {addr_high_q, addr_low_q};
  wire prog_in_range = (prog_addr <= ADDR_MAX);
  wire prog_protected = (prog_addr < protect_limit_in);

  // Software requests; only ones are honoured on trigger bits
  wire fetch_req = wr_ct && sfr_wdata_in[NVAC_FETCH_BIT];
  wire store_ask = wr_ct && sfr_wdata_in[NVAC_STORE_BIT];
  // Data space writes need the open lock and permit already standing;
  // a store with space select high is dropped at once, nothing happens
  wire store_go = store_ask && (lock_q == NVAC_LK_OPEN) && permit_q
                  && !space_q && !store_q;
  wire store_done = store_running_q && tmr_done;

  // Any register write other than to the unlock or control register flags a break; GOT55 also drops on a control write
  wire seq_break = sfr_wr_in && !wr_ul && !wr_ct;

  // Unlock sequencer: 55h then AAh with no other register write between
  always_comb begin
    lock_d = lock_q;
    case (lock_q)
      NVAC_LK_IDLE: begin
        if (wr_ul && sfr_wdata_in == NVAC_KEY_FIRST) begin
          lock_d = NVAC_LK_GOT55;
        end
      end
      NVAC_LK_GOT55: begin
        if (wr_ul && sfr_wdata_in == NVAC_KEY_SECOND) begin
          lock_d = NVAC_LK_OPEN;
        end else if (sfr_wr_in) begin
          lock_d = NVAC_LK_IDLE;
        end
      end
      NVAC_LK_OPEN: begin
        if (sfr_wr_in) begin
          lock_d = NVAC_LK_IDLE; // One trigger per unlock
        end
      end
      default: lock_d = NVAC_LK_IDLE;
    endcase
    if (seq_break && lock_q == NVAC_LK_GOT55) begin
      lock_d = NVAC_LK_IDLE;
    end
  end

  // Read multiplexer; unimplemented bits and the unlock port give zero
  always_comb begin
    rd_mux_d = NVAC_ZERO_BYTE;
    if (sfr_sel_in == NVAC_SEL_DATA_LOW) begin
      rd_mux_d = data_low_q;
    end else if (sfr_sel_in == NVAC_SEL_ADDR_LOW) begin
      rd_mux_d = addr_low_q;
    end else if (sfr_sel_in == NVAC_SEL_DATA_HIGH) begin
      rd_mux_d = {2'b00, data_high_q} & NVAC_DATA_HIGH_MASK;
    end else if (sfr_sel_in == NVAC_SEL_ADDR_HIGH) begin
      rd_mux_d = {3'b000, addr_high_q} & NVAC_ADDR_HIGH_MASK;
    end else if (sfr_sel_in == NVAC_SEL_CONTROL) begin
      rd_mux_d = {space_q, 3'b000, abort_q, permit_q, store_q,
                  fetch_q};
    end else begin
      rd_mux_d = NVAC_ZERO_BYTE;
    end
  end

  // Lock state and read data register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lock_q <= NVAC_LK_IDLE;
      sfr_rdata_out <= NVAC_ZERO_BYTE;
    end else begin
      lock_q <= lock_d;
      sfr_rdata_out <= sfr_rd_in ? rd_mux_d : sfr_rdata_out;
    end
  end

  // Address registers, plain storage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      addr_low_q <= NVAC_ZERO_BYTE;
      addr_high_q <= '0;
    end else begin
      if (wr_al) addr_low_q <= sfr_wdata_in;
      if (wr_ah) addr_high_q <= sfr_wdata_in[4:0];
    end
  end

  // Data registers: loaded by software or by a completed fetch; the
  // fetch lands one cycle after the trigger and is then held
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_low_q <= NVAC_ZERO_BYTE;
      data_high_q <= '0;
    end else if (fetch_pend_q) begin
      if (space_q) begin
        // Out-of-range program words read as zero
        data_low_q <= prog_in_range ? pf_rdata_in[7:0] : NVAC_ZERO_BYTE;
        data_high_q <= prog_in_range ? pf_rdata_in[13:8] : 6'h00;
      end else begin
        data_low_q <= ee_rdata_in;
      end
    end else begin
      if (wr_dl) data_low_q <= sfr_wdata_in;
      if (wr_dh) data_high_q <= sfr_wdata_in[5:0];
    end
  end

  // Control bits; trigger bits are only set by software, cleared here
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      space_q <= 1'b0;
      fetch_q <= 1'b0;
      store_q <= 1'b0;
      fetch_pend_q <= 1'b0;
      store_running_q <= 1'b0;
    end else begin
      if (wr_ct) space_q <= sfr_wdata_in[NVAC_SPACE_BIT];
      fetch_pend_q <= fetch_req && !fetch_q;
      if (fetch_req && !fetch_q) begin
        fetch_q <= 1'b1;
      end else if (fetch_pend_q) begin
        fetch_q <= 1'b0;
      end
      // Permit is not consulted after start, so dropping it is harmless
      if (store_go) begin
        store_q <= 1'b1;
        store_running_q <= 1'b1;
      end else if (store_done) begin
        store_q <= 1'b0;
        store_running_q <= 1'b0;
      end
    end
  end

  // Permit clears on any reset; a warm reset that cuts a running write sets
  // the abort flag so software can see that the write was cut short and retry it
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      permit_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (srst_in) begin
      permit_q <= 1'b0;
      abort_q <= warm_reset_in && store_running_q;
    end else begin
      if (wr_ct) permit_q <= sfr_wdata_in[NVAC_PERMIT_BIT];
      if (store_done) begin
        abort_q <= 1'b0;
      end else if (wr_ct) begin
        abort_q <= sfr_wdata_in[NVAC_ABORT_BIT];
      end
    end
  end

  // Completion flag: set wins over a software clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      store_done_flag_out <= 1'b0;
    end else if (store_done) begin
      store_done_flag_out <= 1'b1;
    end else if (done_flag_clr_in) begin
      store_done_flag_out <= 1'b0;
    end
  end

  // Array-side drive; program space is read-only through this path
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ee_addr_out <= NVAC_ZERO_BYTE;
      ee_wdata_out <= NVAC_ZERO_BYTE;
      ee_erase_out <= 1'b0;
      ee_prog_out <= 1'b0;
      pf_addr_out <= '0;
      prog_port_grant_out <= 1'b0;
    end else begin
      if (!store_running_q) begin
        ee_addr_out <= addr_low_q;
        ee_wdata_out <= data_low_q;
      end
      ee_erase_out <= store_running_q && tmr_erase;
      ee_prog_out <= store_running_q && tmr_busy && !tmr_erase;
      // All in-range words, protected or not; writes never pass
      pf_addr_out <= (prog_in_range && !(prog_protected && 1'b0))
                     ? prog_addr : '0;
      prog_port_grant_out <= prog_port_req_in && !code_protect_in;
    end
  end

  // Self-timed write cycle
  nvac_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(store_go),
    .busy_out(tmr_busy),
    .erase_out(tmr_erase),
    .done_out(tmr_done)
  );
endmodule

// *** nvac_ctrl_props.sv ***
// Port-level assertions for the access controller
`timescale 1ns/10ps
module nvac_ctrl_props
  import nvac_pkg::*;
#(
  parameter int PROG_WORDS = 8192,
  parameter int WRITE_CYCLES = NVAC_WRITE_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [2:0] sfr_sel_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic done_flag_clr_in,
  input wire logic code_protect_in,
  input wire logic prog_port_req_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic ee_erase_out,
  input wire logic ee_prog_out,
  input wire logic prog_port_grant_out,
  input wire logic store_done_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Erase rises one edge after the trigger, the done flag WRITE_CYCLES later
  localparam int DONE_LAT = WRITE_CYCLES;
  logic [1:0] key_q, key_d;
  logic [2:0] arm_q, arm_d;
  wire unl_w = sfr_wr_in && sfr_sel_in == NVAC_SEL_UNLOCK;
  wire go_w = sfr_wr_in && sfr_sel_in == NVAC_SEL_CONTROL
              && sfr_wdata_in[NVAC_STORE_BIT];
  // Key tracker; any other register write in between starts it over
  assign key_d = !sfr_wr_in ? key_q :
    (unl_w && sfr_wdata_in == NVAC_KEY_FIRST) ? 2'h1 :
    (unl_w && sfr_wdata_in == NVAC_KEY_SECOND && key_q == 2'h1) ? 2'h2 : 2'h0;
  assign arm_d = (go_w && key_q == 2'h2) ? 3'h4 :
    (arm_q != 3'h0) ? arm_q - 3'h1 : 3'h0;
  // Arm window opens only after a complete key sequence
  always_ff @(posedge clk_in) begin
    key_q <= srst_in ? 2'h0 : key_d;
    arm_q <= srst_in ? 3'h0 : arm_d;
  end
  a_grant_follows_req: assert property (
    1'b1 |=> prog_port_grant_out == $past(prog_port_req_in && !code_protect_in))
    else $error("grant wrong");
  a_unlock_reads_zero: assert property (
    sfr_rd_in && sfr_sel_in >= NVAC_SEL_UNLOCK |=> sfr_rdata_out == 8'h00)
    else $error("unlock read not zero");
  a_data_high_top: assert property (
    sfr_rd_in && sfr_sel_in == NVAC_SEL_DATA_HIGH |=> sfr_rdata_out[7:6] == 2'h0)
    else $error("data high top bits set");
  a_addr_high_top: assert property (
    sfr_rd_in && sfr_sel_in == NVAC_SEL_ADDR_HIGH |=> sfr_rdata_out[7:5] == 3'h0)
    else $error("addr high top bits set");
  a_control_gap_bits: assert property (
    sfr_rd_in && sfr_sel_in == NVAC_SEL_CONTROL |=> sfr_rdata_out[6:4] == 3'h0)
    else $error("control gap bits set");
  a_erase_then_prog: assert property (
    $rose(ee_prog_out) |-> $past(ee_erase_out) && !ee_erase_out)
    else $error("program without erase");
  a_done_flag_sticky: assert property (
    store_done_flag_out && !done_flag_clr_in |=> store_done_flag_out)
    else $error("done flag dropped");
  a_key_gates_write: assert property (
    $rose(ee_erase_out) |-> arm_q != 3'h0)
    else $error("write without keys");
  a_write_self_timed: assert property (
    $rose(ee_erase_out) |-> ##DONE_LAT $rose(store_done_flag_out))
    else $error("write did not finish");
endmodule
bind nvac_ctrl nvac_ctrl_props #(.PROG_WORDS(PROG_WORDS),
  .WRITE_CYCLES(WRITE_CYCLES)) nvac_ctrl_props_inst (.clk_in(clk_in),
  .srst_in(srst_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
  .sfr_sel_in(sfr_sel_in), .sfr_wdata_in(sfr_wdata_in),
  .done_flag_clr_in(done_flag_clr_in), .code_protect_in(code_protect_in),
  .prog_port_req_in(prog_port_req_in), .sfr_rdata_out(sfr_rdata_out),
  .ee_erase_out(ee_erase_out), .ee_prog_out(ee_prog_out),
  .prog_port_grant_out(prog_port_grant_out),
  .store_done_flag_out(store_done_flag_out));

// *** nvac_mem_model.sv ***
// Behavioural data EEPROM and program flash behind the controller
`timescale 1ns/10ps
module nvac_mem_model (
  input wire logic clk_in,
  input wire logic [7:0] ee_addr_in,
  input wire logic [7:0] ee_wdata_in,
  input wire logic ee_erase_in,
  input wire logic ee_prog_in,
  input wire logic [12:0] pf_addr_in,
  output logic [7:0] ee_rdata_out,
  output logic [13:0] pf_rdata_out
);
  logic [7:0] mem_q [256];
  // Cells start erased; programming only clears bits, so a skipped erase shows
  initial for (int i = 0; i < 256; i++) mem_q[i] = 8'hFF;
  always @(posedge clk_in) begin
    if (ee_erase_in) mem_q[ee_addr_in] <= 8'hFF;
    else if (ee_prog_in) mem_q[ee_addr_in] <= mem_q[ee_addr_in] & ee_wdata_in;
  end
  // Combinational reads on the presented addresses
  assign ee_rdata_out = mem_q[ee_addr_in];
  assign pf_rdata_out = {pf_addr_in, ~pf_addr_in[0]} ^ 14'h1357;
endmodule

// *** nvac_pkg.sv ***
// Shared constants for the indirect non-volatile access controller
package nvac_pkg;
  // Special function register selectors on the core register port
  localparam logic [2:0] NVAC_SEL_DATA_LOW = 3'h0;
  localparam logic [2:0] NVAC_SEL_ADDR_LOW = 3'h1;
  localparam logic [2:0] NVAC_SEL_DATA_HIGH = 3'h2;
  localparam logic [2:0] NVAC_SEL_ADDR_HIGH = 3'h3;
  localparam logic [2:0] NVAC_SEL_CONTROL = 3'h4;
  localparam logic [2:0] NVAC_SEL_UNLOCK = 3'h5;
  // Control register field positions
  localparam int NVAC_FETCH_BIT = 0;
  localparam int NVAC_STORE_BIT = 1;
  localparam int NVAC_PERMIT_BIT = 2;
  localparam int NVAC_ABORT_BIT = 3;
  localparam int NVAC_SPACE_BIT = 7;
  // Implemented-bit masks for the high registers
  localparam logic [7:0] NVAC_DATA_HIGH_MASK = 8'h3F;
  localparam logic [7:0] NVAC_ADDR_HIGH_MASK = 8'h1F;
  localparam logic [7:0] NVAC_ZERO_BYTE = 8'h00;
  // Unlock key bytes
  localparam logic [7:0] NVAC_KEY_FIRST = 8'h55;
  localparam logic [7:0] NVAC_KEY_SECOND = 8'hAA;
  // Memory geometry
  localparam int NVAC_DATA_BYTES = 256;
  localparam int NVAC_PROG_WORD_BITS = 14;
  localparam int NVAC_PROG_ADDR_BITS = 13;
  // Write cycle time in microseconds and its cycle count at 40 MHz
  localparam int NVAC_CLK_MHZ = 40;
  localparam int NVAC_WRITE_TIME_US = 5;
  localparam int NVAC_WRITE_CYCLES = NVAC_WRITE_TIME_US * NVAC_CLK_MHZ;
  // Unlock sequencer states, Gray coded
  typedef enum logic [1:0] {
    NVAC_LK_IDLE = 2'b00,
    NVAC_LK_GOT55 = 2'b01,
    NVAC_LK_OPEN = 2'b11
  } nvac_lock_t;
endpackage

// *** nvac_write_timer.sv ***
// Self-timed erase-then-program cycle counter for data EEPROM writes
`timescale 1ns/10ps
module nvac_write_timer
  import nvac_pkg::*;
#(
  parameter int CYCLES = NVAC_WRITE_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  output logic busy_out,
  output logic erase_out,
  output logic done_out
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(CYCLES / 2);
  localparam logic [CW-1:0] ONE = CW'(1);
  logic [CW-1:0] cnt_q;
  wire at_last = (cnt_q == LAST);

  // First half of the cycle erases, second half programs
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      busy_out <= 1'b0;
      erase_out <= 1'b0;
      done_out <= 1'b0;
      cnt_q <= '0;
    end else begin
      done_out <= busy_out && at_last;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        erase_out <= 1'b1;
        cnt_q <= '0;
      end else if (busy_out) begin
        cnt_q <= cnt_q + ONE;
        erase_out <= (cnt_q + ONE) < HALF;
        if (at_last) begin
          busy_out <= 1'b0;
          erase_out <= 1'b0;
        end
      end
    end
  end
endmodule

// *** tb_nvac_ctrl.sv ***
// Self-checking bench for the indirect non-volatile access controller
`timescale 1ns/10ps
module tb_nvac_ctrl import nvac_pkg::*; ;
  localparam int WC = 8;
  logic clk_in = 1'b0, srst_in = 1'b1, por_in = 1'b1, warm_reset_in = 1'b0;
  logic sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, done_flag_clr_in = 1'b0;
  logic prog_port_req_in = 1'b0, code_protect_in = 1'b0, rd_pend = 1'b0;
  logic [2:0] sfr_sel_in = 3'h0;
  logic [7:0] sfr_wdata_in = 8'h00, sfr_rdata_out, ee_rdata_in, ee_addr_out;
  logic [7:0] ee_wdata_out, d;
  logic [12:0] pf_addr_out, w;
  logic [13:0] pf_rdata_in, e;
  logic ee_erase_out, ee_prog_out, prog_port_grant_out, store_done_flag_out;
  logic [31:0] rs = 32'h944B1DA3;
  logic [7:0] exp_q[$];
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  nvac_ctrl #(.WRITE_CYCLES(WC)) nvac_ctrl_inst (.clk_in(clk_in),
    .srst_in(srst_in), .por_in(por_in), .warm_reset_in(warm_reset_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_sel_in(sfr_sel_in),
    .sfr_wdata_in(sfr_wdata_in), .done_flag_clr_in(done_flag_clr_in),
    .protect_limit_in(13'h0100), .code_protect_in(code_protect_in),
    .prog_port_req_in(prog_port_req_in), .ee_rdata_in(ee_rdata_in),
    .pf_rdata_in(pf_rdata_in), .sfr_rdata_out(sfr_rdata_out),
    .ee_addr_out(ee_addr_out), .ee_wdata_out(ee_wdata_out),
    .ee_erase_out(ee_erase_out), .ee_prog_out(ee_prog_out),
    .pf_addr_out(pf_addr_out), .prog_port_grant_out(prog_port_grant_out),
    .store_done_flag_out(store_done_flag_out));
  nvac_mem_model nvac_mem_model_inst (.clk_in(clk_in),
    .ee_addr_in(ee_addr_out), .ee_wdata_in(ee_wdata_out),
    .ee_erase_in(ee_erase_out), .ee_prog_in(ee_prog_out),
    .pf_addr_in(pf_addr_out), .ee_rdata_out(ee_rdata_in),
    .pf_rdata_out(pf_rdata_in));
  initial forever #12.5 clk_in = ~clk_in;
  // Xorshift step for random addresses and data
  function automatic logic [31:0] xs(logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] ex, logic [7:0] sn);
    n_checks++;
    if (sn !== ex) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  // One register-port cycle; the caller is always at a falling edge
  task automatic op(logic wr, logic rd, logic [2:0] s, logic [7:0] v);
    sfr_wr_in = wr;
    sfr_rd_in = rd;
    sfr_sel_in = s;
    sfr_wdata_in = v;
    @(negedge clk_in);
  endtask
  task automatic rd(logic [2:0] s, logic [7:0] ex);
    exp_q.push_back(ex);
    op(1'b0, 1'b1, s, 8'h00);
  endtask
  // Keys must have no other register write between them; here they go back to back
  task automatic store(logic [7:0] ctl);
    op(1'b1, 1'b0, NVAC_SEL_UNLOCK, NVAC_KEY_FIRST);
    op(1'b1, 1'b0, NVAC_SEL_UNLOCK, NVAC_KEY_SECOND);
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, ctl);
    op(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  task automatic done_is(logic v);
    chk("done", {7'h00, v}, {7'h00, store_done_flag_out});
  endtask
  // Read data lands one cycle after the strobe; pair it with the oldest note
  always @(posedge clk_in) rd_pend <= sfr_rd_in;
  always @(negedge clk_in) if (rd_pend) chk("rdata", exp_q.pop_front(), sfr_rdata_out);
  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    por_in = 1'b0;
    for (int k = 0; k < 8; k++) rd(k[2:0], 8'h00);
    op(1'b1, 1'b0, NVAC_SEL_DATA_HIGH, 8'hFF);
    rd(NVAC_SEL_DATA_HIGH, 8'h3F);
    op(1'b1, 1'b0, NVAC_SEL_ADDR_HIGH, 8'hFF);
    rd(NVAC_SEL_ADDR_HIGH, 8'h1F);
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'hF0);
    rd(NVAC_SEL_CONTROL, 8'h80);
    rs = xs(rs);
    op(1'b1, 1'b0, NVAC_SEL_ADDR_LOW, rs[7:0]);
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h00);
    store(8'h02);
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h04);
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h06);
    op(1'b1, 1'b0, NVAC_SEL_UNLOCK, NVAC_KEY_FIRST);
    op(1'b1, 1'b0, NVAC_SEL_DATA_LOW, 8'h5A);
    // A write between the keys breaks the sequence, so this trigger is void
    op(1'b1, 1'b0, NVAC_SEL_UNLOCK, NVAC_KEY_SECOND);
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h06);
    repeat (2 * WC) op(1'b0, 1'b0, 3'h0, 8'h00);
    done_is(1'b0);
    rd(NVAC_SEL_CONTROL, 8'h04);
    for (int i = 0; i < 2; i++) begin
      rs = xs(rs);
      d = rs[15:8];
      op(1'b1, 1'b0, NVAC_SEL_DATA_LOW, d);
      op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h04);
      store(8'h06);
      op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h00);
      for (int j = 0; j < 40 && store_done_flag_out !== 1'b1; j++) begin
        op(1'b0, 1'b0, 3'h0, 8'h00);
      end
      done_is(1'b1);
      rd(NVAC_SEL_CONTROL, 8'h00);
      done_is(1'b1);
      done_flag_clr_in = 1'b1;
      op(1'b0, 1'b0, 3'h0, 8'h00);
      done_flag_clr_in = 1'b0;
      op(1'b0, 1'b0, 3'h0, 8'h00);
      done_is(1'b0);
      op(1'b1, 1'b0, NVAC_SEL_DATA_LOW, ~d);
      op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h01);
      op(1'b0, 1'b0, 3'h0, 8'h00);
      rd(NVAC_SEL_DATA_LOW, d);
    end
    w = rs[28:16];
    e = {w, ~w[0]} ^ 14'h1357;
    op(1'b1, 1'b0, NVAC_SEL_ADDR_HIGH, {3'h0, w[12:8]});
    op(1'b1, 1'b0, NVAC_SEL_ADDR_LOW, w[7:0]);
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h84);
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h85);
    op(1'b0, 1'b0, 3'h0, 8'h00);
    op(1'b0, 1'b0, 3'h0, 8'h00);
    rd(NVAC_SEL_DATA_LOW, e[7:0]);
    rd(NVAC_SEL_DATA_HIGH, {2'h0, e[13:8]});
    store(8'h86);
    rd(NVAC_SEL_CONTROL, 8'h84);
    for (int k = 0; k < 4; k++) begin
      prog_port_req_in = k[0];
      code_protect_in = k[1];
      op(1'b0, 1'b0, 3'h0, 8'h00);
      chk("grant", {7'h00, k[0] & ~k[1]}, {7'h00, prog_port_grant_out});
    end
    op(1'b1, 1'b0, NVAC_SEL_CONTROL, 8'h04);
    store(8'h06);
    srst_in = 1'b1;
    warm_reset_in = 1'b1;
    op(1'b0, 1'b0, 3'h0, 8'h00);
    srst_in = 1'b0;
    warm_reset_in = 1'b0;
    rd(NVAC_SEL_CONTROL, 8'h08);
    srst_in = 1'b1;
    por_in = 1'b1;
    op(1'b0, 1'b0, 3'h0, 8'h00);
    srst_in = 1'b0;
    por_in = 1'b0;
    rd(NVAC_SEL_CONTROL, 8'h00);
    op(1'b0, 1'b0, 3'h0, 8'h00);
    summarize();
  end
endmodule
